// *** rtl/shb_pkg.sv ***
// shared constants and functions for the serial host boot link
package shb_pkg;
    // register addresses (address byte values)
    localparam logic [7:0] ADR_GEN_RESET   = 8'h01;
    localparam logic [7:0] ADR_CSUM_A_UP   = 8'ha9;
    localparam logic [7:0] ADR_CSUM_A_LO   = 8'haa;
    localparam logic [7:0] ADR_CSUM_B_UP   = 8'hb8;
    localparam logic [7:0] ADR_CSUM_B_LO   = 8'hb9;
    localparam logic [7:0] ADR_POWER_DOWN  = 8'hc0;
    localparam logic [7:0] ADR_MODE_CTRL   = 8'hc1;
    localparam logic [7:0] ADR_PRODUCT_ID  = 8'hc5;
    localparam logic [7:0] ADR_STATUS      = 8'hc6;
    localparam logic [7:0] ADR_PROG_PORT   = 8'hc8;
    localparam logic [7:0] ADR_IMAGE_VER   = 8'hc9;
    // address byte whose data bytes carry the image stream while loading
    localparam logic [7:0] ADR_IMAGE_DATA  = 8'hc8;
    localparam logic [15:0] DEAD_CODE      = 16'hdead;
    localparam int         STATUS_PROG_BIT = 0;
    // boot select encoding {high, low}
    localparam logic [1:0] BOOT_HOST       = 2'b11;
    localparam logic [1:0] BOOT_RESERVED   = 2'b10;
    localparam logic [1:0] BOOT_EEPROM     = 2'b01;
    localparam logic [1:0] BOOT_NONE       = 2'b00;
    // mode control values
    localparam logic [1:0] MODE_IDLE       = 2'b00;
    // write latency
    localparam int         CLK_MHZ         = 100;
    localparam int         LATENCY_US      = 250;
    localparam int         LATENCY_CYC     = LATENCY_US * CLK_MHZ;
    // apb register map of the host controller
    localparam logic [7:0] APB_CTRL        = 8'h00;
    localparam logic [7:0] APB_TXDATA      = 8'h04;
    localparam logic [7:0] APB_RXDATA      = 8'h08;
    localparam logic [7:0] APB_STAT        = 8'h0c;
    localparam int         CTRL_START      = 0;
    localparam int         CTRL_READ       = 1;
    localparam int         CTRL_NBYTES     = 4;
    localparam int         CTRL_ADDR       = 8;
    localparam int         CLK_DIV         = 4;

    // data bytes that follow each address byte
    function automatic logic [2:0] shb_data_bytes(input logic [7:0] adr);
        unique case (adr)
            ADR_GEN_RESET:  shb_data_bytes = 3'd0;
            ADR_PROG_PORT:  shb_data_bytes = 3'd4;
            default:        shb_data_bytes = 3'd2;
        endcase
    endfunction

    // address byte selects the direction
    function automatic logic shb_is_read(input logic [7:0] adr);
        shb_is_read = (adr == ADR_CSUM_A_UP) || (adr == ADR_CSUM_A_LO) ||
                      (adr == ADR_CSUM_B_UP) || (adr == ADR_CSUM_B_LO) ||
                      (adr == ADR_PRODUCT_ID) || (adr == ADR_STATUS) ||
                      (adr == ADR_IMAGE_VER);
    endfunction
endpackage

// *** rtl/shb_if.sv ***
// serial link between host controller and device
`timescale 1ns/1ns
interface shb_if;
    logic bus_select_n;
    logic serial_clk;
    logic host_command_in;
    logic reply_out;
    logic reply_oe;
    modport host (output bus_select_n, output serial_clk, output host_command_in,
                  input reply_out, input reply_oe);
    modport dev  (input bus_select_n, input serial_clk, input host_command_in,
                  output reply_out, output reply_oe);
endinterface

// *** rtl/shb_sync.sv ***
// two flip-flop synchroniser for link pins
`timescale 1ns/1ns
module shb_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule

// *** rtl/shb_device.sv ***
// device end: serial slave, image boot, checksum report and activation
//
// What this block does
// RULE_01: one address byte, then data bytes
// RULE_02: sample command line on clock rise
// RULE_03: reply valid while serial clock high
// RULE_04: host holds select low per transfer
// RULE_05: address byte fixes data byte count
// RULE_06: address sets direction; lines never both
// RULE_07: shift most significant bit first
// RULE_08: write reaches register within 250us
// RULE_09: eight-bit commands; 0x01 is general reset
// RULE_10: clock idles either level; gaps allowed
// RULE_11: boot pins read only at reset; ST_LOAD also re-reads them every cycle to choose eeprom loading
// RULE_12: boot pin encoding selects load source
// RULE_13: report ident, version, two checksums
// RULE_14: activation code enters idle, sets flag
// RULE_15: activation clears report registers
// RULE_16: bad code gives dead, locks up
// RULE_17: boot none reset skips image load
// RULE_18: nothing works until loaded, activated
// RULE_19: eeprom load runs without host
// RULE_20: host sets pins then streams image
// RULE_21: enable sections, configure, then mode
// RULE_22: route outputs about 1ms after mode; mode_ctrl_o follows the register with no added delay
// RULE_23: idle at reset; programming only idle
`timescale 1ns/1ns
module shb_device
    import shb_pkg::*;
#(
    parameter int          LATENCY  = LATENCY_CYC,
    parameter int          IMG_WORDS = 4,
    parameter logic [31:0] ACT_CODE = 32'h1234_5678,
    parameter logic [15:0] PROD_ID  = 16'h0a5a,   // arbitrary value
    parameter logic [15:0] IMG_VER  = 16'h0105,
    parameter logic [31:0] CSUM_A   = 32'h1111_2222,
    parameter logic [31:0] CSUM_B   = 32'h3333_4444
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // link
    shb_if.dev               link,
    // boot straps
    input  wire logic        boot_select_high_i,
    input  wire logic        boot_select_low_i,
    // eeprom image source
    input  wire logic        eeprom_valid_i,
    output logic             eeprom_req_o,
    // user side
    output logic [15:0]      power_down_o,
    output logic [15:0]      mode_ctrl_o,
    output logic             active_o,
    output logic             locked_o
);
    typedef enum {ST_BOOT, ST_LOAD, ST_WAIT_ACT, ST_ACTIVE, ST_DEAD} shb_state_t;

    // =======================================================
    // link synchronisers
    logic [4:0] pins;
    shb_sync #(.W(5)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({link.bus_select_n, link.serial_clk, link.host_command_in,
                     boot_select_high_i, eeprom_valid_i}),
        .sync_o    (pins)
    );
    logic sel_n, sck, cmd, bhi, ev, blo_meta_ff, blo_ff;
    assign {sel_n, sck, cmd, bhi, ev} = pins;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            blo_meta_ff <= 1'b0;
            blo_ff      <= 1'b0;
        end else begin
            blo_meta_ff <= boot_select_low_i;
            blo_ff      <= blo_meta_ff;
        end
    end

    // =======================================================
    // serial shifter and sequencer state
    shb_state_t  st_ff, nxt_st;
    logic        sck_ff;
    logic        started_ff, nxt_started;
    logic [2:0]  bit_ff, nxt_bit;
    logic [2:0]  byte_ff, nxt_byte;
    logic [2:0]  need_ff, nxt_need;
    logic [7:0]  adr_ff, nxt_adr;
    logic [7:0]  sh_ff, nxt_sh;
    logic [31:0] wdat_ff, nxt_wdat;
    logic [15:0] rdat_ff, nxt_rdat;
    logic        rd_ff, nxt_rd;
    logic        oe_ff, nxt_oe;
    logic [7:0]  pend_adr_ff, nxt_pend_adr;
    logic [31:0] pend_dat_ff, nxt_pend_dat;
    logic        pend_ff, nxt_pend;
    logic [31:0] lat_ff, nxt_lat;
    logic [15:0] imgcnt_ff, nxt_imgcnt;
    logic        reported_ff, nxt_reported;
    logic [15:0] pd_ff, nxt_pd, mc_ff, nxt_mc;
    logic        ereq_ff, nxt_ereq;

    logic rise, fall;
    assign rise = sck & ~sck_ff;                                   // [RULE_02]
    assign fall = ~sck & sck_ff;

    function automatic logic [15:0] rd_value(input logic [7:0] a, input logic rep,
                                             input logic act);
        unique case (a)
            ADR_CSUM_A_UP:  rd_value = rep ? CSUM_A[31:16] : 16'h0000;
            ADR_CSUM_A_LO:  rd_value = rep ? CSUM_A[15:0]  : 16'h0000;
            ADR_CSUM_B_UP:  rd_value = rep ? CSUM_B[31:16] : 16'h0000;
            ADR_CSUM_B_LO:  rd_value = rep ? CSUM_B[15:0]  : 16'h0000;
            ADR_PRODUCT_ID: rd_value = rep ? PROD_ID : 16'h0000;  // [RULE_13] [RULE_15]
            ADR_IMAGE_VER:  rd_value = rep ? IMG_VER : 16'h0000;
            ADR_STATUS:     rd_value = {15'h0000, act};            // [RULE_14]
            default:        rd_value = 16'h0000;
        endcase
    endfunction

    always_comb begin
        nxt_st = st_ff;  nxt_started = started_ff;  nxt_bit = bit_ff;
        nxt_byte = byte_ff;  nxt_need = need_ff;  nxt_adr = adr_ff;
        nxt_sh = sh_ff;  nxt_wdat = wdat_ff;  nxt_rdat = rdat_ff;
        nxt_rd = rd_ff;  nxt_oe = oe_ff;
        nxt_pend_adr = pend_adr_ff;  nxt_pend_dat = pend_dat_ff;
        nxt_pend = pend_ff;  nxt_lat = lat_ff;  nxt_imgcnt = imgcnt_ff;
        nxt_reported = reported_ff;  nxt_pd = pd_ff;  nxt_mc = mc_ff;
        nxt_ereq = 1'b0;
        // frame delimiting; clock level at select edges does not matter
        if (sel_n) begin                                           // [RULE_04] [RULE_10]
            nxt_started = 1'b0;  nxt_bit = 3'd0;  nxt_byte = 3'd0;
            nxt_oe = 1'b0;  nxt_rd = 1'b0;
        end else begin
            if (!started_ff) begin
                nxt_started = 1'b1;
            end else if (rise && !rd_ff) begin
                nxt_sh  = {sh_ff[6:0], cmd};                       // [RULE_07]
                nxt_bit = bit_ff + 3'd1;
                if (bit_ff == 3'd7) begin
                    if (byte_ff == 3'd0) begin                     // [RULE_01]
                        nxt_adr  = {sh_ff[6:0], cmd};
                        nxt_need = shb_data_bytes({sh_ff[6:0], cmd});    // [RULE_05]
                        nxt_rd   = shb_is_read({sh_ff[6:0], cmd});       // [RULE_06]
                        nxt_rdat = (st_ff == ST_DEAD) ? DEAD_CODE :      // [RULE_16]
                                   rd_value({sh_ff[6:0], cmd}, reported_ff,
                                            st_ff == ST_ACTIVE);
                        nxt_byte = 3'd1;
                        if ({sh_ff[6:0], cmd} == ADR_GEN_RESET &&
                            st_ff != ST_DEAD) begin  // [RULE_09] [RULE_16]
                            nxt_st = ST_BOOT;
                            nxt_reported = 1'b0;
                        end
                    end else if (byte_ff <= need_ff) begin
                        nxt_wdat = {wdat_ff[23:0], sh_ff[6:0], cmd};
                        nxt_byte = byte_ff + 3'd1;
                        if (byte_ff == need_ff) begin
                            nxt_pend = 1'b1;
                            nxt_pend_adr = adr_ff;
                            nxt_pend_dat = {wdat_ff[23:0], sh_ff[6:0], cmd};
                            nxt_lat = '0;
                        end
                    end
                end
            end else if (rd_ff && fall) begin
                // reply changes on the fall so it is stable while high
                nxt_oe = 1'b1;                                     // [RULE_03]
                if (oe_ff) begin
                    nxt_rdat = {rdat_ff[14:0], 1'b0};              // [RULE_07]
                end
            end
        end
        // delayed register update, modelling internal polling
        if (pend_ff) begin
            nxt_lat = lat_ff + 32'd1;
            if (lat_ff == 32'(LATENCY - 1)) begin                  // [RULE_08]
                nxt_pend = 1'b0;
                unique case (st_ff)
                    ST_LOAD: if (pend_adr_ff == ADR_IMAGE_DATA) begin    // [RULE_20]
                        nxt_imgcnt = imgcnt_ff + 16'd1;
                    end
                    ST_WAIT_ACT: if (pend_adr_ff == ADR_PROG_PORT) begin
                        if (pend_dat_ff == ACT_CODE) begin         // [RULE_14]
                            nxt_st = ST_ACTIVE;
                            nxt_reported = 1'b0;                   // [RULE_15]
                            nxt_mc = {14'h0000, MODE_IDLE};
                        end else begin
                            nxt_st = ST_DEAD;                      // [RULE_16]
                        end
                    end
                    ST_ACTIVE: begin                               // [RULE_18]
                        if (pend_adr_ff == ADR_POWER_DOWN) nxt_pd = pend_dat_ff[15:0];
                        if (pend_adr_ff == ADR_MODE_CTRL) nxt_mc = pend_dat_ff[15:0]; // [RULE_21]
                        // programming port only in idle                 [RULE_23]
                    end
                    default: ;
                endcase
            end
        end
        unique case (st_ff)
            ST_BOOT: begin
                // straps are only trusted once both sync stages have filled
                nxt_imgcnt = imgcnt_ff[1] ? '0 : imgcnt_ff + 16'd1;
                nxt_mc = {14'h0000, MODE_IDLE};                    // [RULE_23]
                nxt_pd = 16'h0000;
                unique case (imgcnt_ff[1] ? {bhi, blo_ff} : BOOT_RESERVED) // [RULE_11] [RULE_12]
                    BOOT_HOST, BOOT_EEPROM: nxt_st = ST_LOAD;
                    BOOT_NONE: begin                               // [RULE_17]
                        nxt_st = ST_WAIT_ACT;
                        nxt_reported = 1'b1;
                    end
                    default: nxt_st = ST_BOOT;
                endcase
            end
            ST_LOAD: begin
                if ({bhi, blo_ff} == BOOT_EEPROM) begin            // [RULE_19]
                    nxt_ereq = ~ev;
                    if (ev && !ereq_ff) nxt_imgcnt = imgcnt_ff + 16'd1;
                end
                if (imgcnt_ff == 16'(IMG_WORDS)) begin
                    nxt_st = ST_WAIT_ACT;
                    nxt_reported = 1'b1;                           // [RULE_13]
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_ff <= ST_BOOT;  sck_ff <= 1'b0;  started_ff <= 1'b0;
            bit_ff <= '0;  byte_ff <= '0;  need_ff <= '0;  adr_ff <= '0;
            sh_ff <= '0;  wdat_ff <= '0;  rdat_ff <= '0;  rd_ff <= 1'b0;
            oe_ff <= 1'b0;  pend_adr_ff <= '0;
            pend_dat_ff <= '0;  pend_ff <= 1'b0;  lat_ff <= '0;
            imgcnt_ff <= '0;  reported_ff <= 1'b0;  pd_ff <= '0;
            mc_ff <= '0;  ereq_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;  sck_ff <= sck;  started_ff <= nxt_started;
            bit_ff <= nxt_bit;  byte_ff <= nxt_byte;  need_ff <= nxt_need;
            adr_ff <= nxt_adr;  sh_ff <= nxt_sh;  wdat_ff <= nxt_wdat;
            rdat_ff <= nxt_rdat;  rd_ff <= nxt_rd;
            oe_ff <= nxt_oe;  pend_adr_ff <= nxt_pend_adr;
            pend_dat_ff <= nxt_pend_dat;  pend_ff <= nxt_pend;
            lat_ff <= nxt_lat;  imgcnt_ff <= nxt_imgcnt;
            reported_ff <= nxt_reported;  pd_ff <= nxt_pd;  mc_ff <= nxt_mc;
            ereq_ff <= nxt_ereq;
        end
    end

    assign link.reply_out = rdat_ff[15] & oe_ff;
    assign link.reply_oe  = oe_ff;                                 // [RULE_06]
    assign eeprom_req_o   = ereq_ff;
    assign power_down_o   = pd_ff;
    assign mode_ctrl_o    = mc_ff;                                 // [RULE_22]
    assign active_o       = (st_ff == ST_ACTIVE);
    assign locked_o       = (st_ff == ST_DEAD);
endmodule

// *** rtl/shb_host.sv ***
// host end: apb controlled serial master
`timescale 1ns/1ns
module shb_host
    import shb_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // link
    shb_if.host              link
);
    typedef enum {H_IDLE, H_LOW, H_HIGH, H_DONE} shb_hstate_t;
    shb_hstate_t st_ff, nxt_st;
    logic [2:0]  div_ff, nxt_div;
    logic [5:0]  bits_ff, nxt_bits;
    logic [39:0] sh_ff, nxt_sh;
    logic [31:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic        sel_n_ff, nxt_sel_n, sck_ff, nxt_sck, busy_ff, nxt_busy;
    logic [31:0] prd_ff, nxt_prd;
    logic        rdy_ff, nxt_rdy, err_ff, nxt_err;
    logic        rep_meta_ff, rep_ff;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rep_meta_ff <= 1'b0;
            rep_ff      <= 1'b0;
        end else begin
            rep_meta_ff <= link.reply_out;
            rep_ff      <= rep_meta_ff;
        end
    end

    logic acc;
    assign acc = psel_i & penable_i & ~rdy_ff;
    always_comb begin
        nxt_st = st_ff;  nxt_div = div_ff;  nxt_bits = bits_ff;  nxt_sh = sh_ff;
        nxt_rx = rx_ff;  nxt_tx = tx_ff;  nxt_ctrl = ctrl_ff;
        nxt_sel_n = sel_n_ff;  nxt_sck = sck_ff;  nxt_busy = busy_ff;
        nxt_prd = prd_ff;  nxt_rdy = 1'b0;  nxt_err = 1'b0;
        if (acc) begin
            nxt_rdy = 1'b1;
            if (pwrite_i) begin
                unique case (paddr_i)
                    APB_CTRL:   nxt_ctrl = pwdata_i[15:0];
                    APB_TXDATA: nxt_tx = pwdata_i;
                    default:    nxt_err = (paddr_i != APB_RXDATA) && (paddr_i != APB_STAT);
                endcase
            end else begin
                unique case (paddr_i)
                    APB_CTRL:   nxt_prd = {16'h0000, ctrl_ff};
                    APB_TXDATA: nxt_prd = tx_ff;
                    APB_RXDATA: nxt_prd = rx_ff;
                    APB_STAT:   nxt_prd = {31'h0, busy_ff};
                    default: begin
                        nxt_prd = 32'h0;
                        nxt_err = 1'b1;
                    end
                endcase
            end
        end
        unique case (st_ff)
            H_IDLE: if (ctrl_ff[CTRL_START] && !busy_ff) begin
                nxt_busy = 1'b1;  nxt_sel_n = 1'b0;  nxt_sck = 1'b0;
                nxt_ctrl[CTRL_START] = 1'b0;
                nxt_sh = {ctrl_ff[CTRL_ADDR +: 8], tx_ff};
                nxt_bits = 6'd8 + {ctrl_ff[CTRL_NBYTES +: 3], 3'b000};
                nxt_rx = '0;  nxt_div = '0;  nxt_st = H_LOW;
            end
            H_LOW: begin
                nxt_div = div_ff + 3'd1;
                if (div_ff == 3'(CLK_DIV - 1)) begin
                    nxt_div = '0;  nxt_sck = 1'b1;  nxt_st = H_HIGH;
                end
            end
            H_HIGH: begin
                nxt_div = div_ff + 3'd1;
                if (div_ff == 3'(CLK_DIV - 1)) begin
                    nxt_div = '0;  nxt_sck = 1'b0;
                    // end of the high phase, clear of the reply's sync lag
                    nxt_rx = {rx_ff[30:0], rep_ff};
                    nxt_sh = {sh_ff[38:0], 1'b0};
                    nxt_bits = bits_ff - 6'd1;
                    nxt_st = (bits_ff == 6'd1) ? H_DONE : H_LOW;
                end
            end
            H_DONE: begin
                nxt_sel_n = 1'b1;  nxt_busy = 1'b0;  nxt_st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_ff <= H_IDLE;  div_ff <= '0;  bits_ff <= '0;  sh_ff <= '0;
            rx_ff <= '0;  tx_ff <= '0;  ctrl_ff <= '0;  sel_n_ff <= 1'b1;
            sck_ff <= 1'b0;  busy_ff <= 1'b0;  prd_ff <= '0;
            rdy_ff <= 1'b0;  err_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;  div_ff <= nxt_div;  bits_ff <= nxt_bits;
            sh_ff <= nxt_sh;  rx_ff <= nxt_rx;  tx_ff <= nxt_tx;
            ctrl_ff <= nxt_ctrl;  sel_n_ff <= nxt_sel_n;  sck_ff <= nxt_sck;
            busy_ff <= nxt_busy;  prd_ff <= nxt_prd;  rdy_ff <= nxt_rdy;
            err_ff <= nxt_err;
        end
    end

    // data bits msb first; address in top byte of shifter
    assign link.bus_select_n    = sel_n_ff;
    assign link.serial_clk      = sck_ff;
    assign link.host_command_in = !sel_n_ff && sh_ff[39] &&
        (!ctrl_ff[CTRL_READ] || bits_ff > {ctrl_ff[CTRL_NBYTES +: 3], 3'b000});
    assign prdata_o  = prd_ff;
    assign pready_o  = rdy_ff;
    assign pslverr_o = err_ff;
endmodule

// *** tb/shb_link_props.sv ***
// link protocol checks for the serial host boot link
`timescale 1ns/1ns
module shb_link_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // link
    input wire logic bus_select_n,
    input wire logic serial_clk,
    input wire logic host_command_in,
    input wire logic reply_out,
    input wire logic reply_oe
);
    logic [5:0] bits_ff;
    logic [5:0] nxt_bits;
    logic       sclk_ff;
    logic       nxt_sclk;
    // ========================================
    // bit count of the current transfer
    always_comb begin
        nxt_sclk = serial_clk;
        nxt_bits = bus_select_n ? 6'h00 : bits_ff + {5'h00, serial_clk & ~sclk_ff};
    end
    always_ff @(posedge ref_clk_i) begin
        sclk_ff <= rst_n_i ? nxt_sclk : 1'b0;
        bits_ff <= rst_n_i ? nxt_bits : 6'h00;
    end
    // ========================================
    // properties
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence high_phase;
        serial_clk [*4] ##1 !serial_clk;
    endsequence
    sequence held_select;
        !bus_select_n [*8];
    endsequence
    bit_period_a: assert property ($rose(serial_clk) |-> high_phase)
        else $error("serial clock high phase wrong");
    whole_byte_a: assert property ($rose(bus_select_n) |-> bits_ff[2:0] == 3'h0)
        else $error("transfer not whole bytes");
    frame_len_a: assert property ($rose(bus_select_n) |-> bits_ff <= 6'd40)
        else $error("transfer too long");
    select_hold_a: assert property ($fell(bus_select_n) |-> held_select)
        else $error("select released early");
    reply_quiet_a: assert property (bus_select_n [*4] |-> !reply_oe)
        else $error("reply driven while deselected");
    reply_steady_a: assert property (serial_clk && $past(serial_clk) && reply_oe
        && $past(reply_oe) |-> $stable(reply_out)) else $error("reply moved in high phase");
    cmd_steady_a: assert property (!bus_select_n && serial_clk && $past(serial_clk)
        |-> $stable(host_command_in)) else $error("command moved in high phase");
    idle_reset_a: assert property ($rose(rst_n_i) |-> bus_select_n && !serial_clk)
        else $error("link not idle after reset");
endmodule

// *** tb/serial_host_boot_activation_tb.sv ***
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ns
module serial_host_boot_activation_tb;
    import shb_pkg::*;
    localparam int          LAT  = 20;
    localparam logic [31:0] ACT  = 32'h1234_5678;
    localparam logic [31:0] CS_A = 32'h1111_2222;
    localparam logic [31:0] CS_B = 32'h3333_4444;
    localparam logic [15:0] PID  = 16'h0a5a; // arbitrary value
    localparam logic [15:0] VER  = 16'h0105;
    typedef struct packed {logic [7:0] adr; logic [15:0] exp;} shb_row_t;
    shb_row_t    rows [6] = '{'{ADR_CSUM_A_UP, CS_A[31:16]}, '{ADR_CSUM_A_LO, CS_A[15:0]},
        '{ADR_CSUM_B_UP, CS_B[31:16]}, '{ADR_CSUM_B_LO, CS_B[15:0]},
        '{ADR_PRODUCT_ID, PID}, '{ADR_IMAGE_VER, VER}};
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [1:0]  boot      = BOOT_HOST;
    logic [31:0] prdata, rsp;
    logic        pready, pslverr, ee_req, act, lck, last_err, sclk_d;
    logic [15:0] pd, mc, q;
    logic [7:0]  mon;
    int          num_errors = 0;
    int          n_compared = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    shb_if i_shb_if ();
    shb_host i_shb_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(i_shb_if.host));
    shb_device #(.LATENCY(LAT), .ACT_CODE(ACT), .PROD_ID(PID), .IMG_VER(VER), .CSUM_A(CS_A),
        .CSUM_B(CS_B)) i_shb_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .link(i_shb_if.dev), .boot_select_high_i(boot[1]), .boot_select_low_i(boot[0]),
        .eeprom_valid_i(1'b0), .eeprom_req_o(ee_req), .power_down_o(pd), .mode_ctrl_o(mc),
        .active_o(act), .locked_o(lck));
    shb_link_props i_shb_link_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .bus_select_n(i_shb_if.bus_select_n), .serial_clk(i_shb_if.serial_clk),
        .host_command_in(i_shb_if.host_command_in), .reply_out(i_shb_if.reply_out),
        .reply_oe(i_shb_if.reply_oe));
    // command bits as the device should see them, on clock rises
    always @(posedge ref_clk_i) begin
        sclk_d <= i_shb_if.serial_clk;
        if (!i_shb_if.bus_select_n && i_shb_if.serial_clk && !sclk_d) begin
            mon <= {mon[6:0], i_shb_if.host_command_in};
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // write data sits msb aligned; reads come back in the low half
    task automatic xfer(input logic [7:0] adr, input logic rd, input logic [2:0] nb,
                        input logic [31:0] wd, output logic [15:0] res);
        logic [31:0] r;
        apb(1'b1, APB_TXDATA, wd, r);
        apb(1'b1, APB_CTRL, {16'h0, adr, 1'b0, nb, 2'b00, rd, 1'b1}, r);
        r = 32'h1;
        while (r[0] !== 1'b0) apb(1'b0, APB_STAT, 32'h0, r);
        apb(1'b0, APB_RXDATA, 32'h0, r);
        res = r[15:0];
        repeat (LAT + 4) @(posedge ref_clk_i);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        num_errors++;
        $display("unexpected at %0t: timeout", $time);
        end_sim;
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) xfer(ADR_IMAGE_DATA, 1'b0, 3'd4, 32'hc0de_0000 + i, q);
        check({15'h0, act}, 16'h0);
        check({15'h0, ee_req}, 16'h0);
        foreach (rows[k]) begin
            xfer(rows[k].adr, 1'b1, 3'd2, 32'h0, q);
            check(q, rows[k].exp);
        end
        $display("test report done");
        apb(1'b0, 8'h10, 32'h0, rsp);
        check({15'h0, last_err}, 16'h1);
        xfer(ADR_PROG_PORT, 1'b0, 3'd4, ACT, q);
        xfer(ADR_STATUS, 1'b1, 3'd2, 32'h0, q);
        check({15'h0, q[STATUS_PROG_BIT]}, 16'h1);
        xfer(ADR_CSUM_A_UP, 1'b1, 3'd2, 32'h0, q);
        check(q, 16'h0);
        xfer(ADR_POWER_DOWN, 1'b0, 3'd2, 32'h00ff_0000, q);
        check(pd, 16'h00ff);
        xfer(ADR_MODE_CTRL, 1'b0, 3'd2, 32'h0001_0000, q);
        check(mc, 16'h0001);
        $display("test activation done");
        boot <= BOOT_NONE;
        xfer(ADR_GEN_RESET, 1'b0, 3'd0, 32'h0, q);
        check({8'h0, mon}, {8'h0, ADR_GEN_RESET});
        check({14'h0, mc[1:0]}, {14'h0, MODE_IDLE});
        xfer(ADR_CSUM_A_UP, 1'b1, 3'd2, 32'h0, q);
        check(q, CS_A[31:16]);
        xfer(ADR_PROG_PORT, 1'b0, 3'd4, ~ACT, q);
        xfer(ADR_GEN_RESET, 1'b0, 3'd0, 32'h0, q);
        xfer(ADR_CSUM_A_UP, 1'b1, 3'd2, 32'h0, q);
        check(q, DEAD_CODE);
        check({14'h0, lck, act}, 16'h2);
        $display("test lock done");
        end_sim;
    end
endmodule
